// ---- common/smwc_pkg.sv ----
// Purpose: Constants for the deep stop wake controller
// Assumes: 200 MHz main clock, 8-bit register port
// Notes:   Offsets are word indices on the plain register port
package smwc_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] SMWC_OFF_PSAVE  = 4'h0;
   localparam logic [3:0] SMWC_OFF_MODE   = 4'h1;
   localparam logic [3:0] SMWC_OFF_STAB   = 4'h2;
   localparam logic [3:0] SMWC_OFF_CLKSEL = 4'h3;
   localparam logic [3:0] SMWC_OFF_STATUS = 4'h4;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int SMWC_BIT_TRIGGER   = 1;
   localparam int SMWC_BIT_MASK_INT  = 4;
   localparam int SMWC_BIT_MASK_WDNM = 6;
   localparam int SMWC_BIT_MASK_PNMI = 7;
   localparam int SMWC_BIT_TMR_RDIV8 = 0;
   localparam int SMWC_BIT_WDT_RING  = 1;
   localparam int SMWC_BIT_SYNC_EXT  = 2;
   localparam int SMWC_BIT_ASYN_EXT  = 3;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] SMWC_PSAVE_RST  = 8'h00;
   localparam logic [7:0] SMWC_PSAVE_WMSK = 8'hd2;
   localparam logic [7:0] SMWC_MODE_RST   = 8'h00;
   localparam logic [7:0] SMWC_MODE_WMSK  = 8'h03;
   localparam logic [7:0] SMWC_CLKSEL_RST = 8'h00;
   localparam logic [7:0] SMWC_CLKSEL_WMSK = 8'h0f;
   localparam logic [1:0] SMWC_MODE_STOP  = 2'h1;
   localparam logic [2:0] SMWC_STAB_RST   = 3'h4;
   localparam logic [2:0] SMWC_STAB_WMSK  = 3'h7;
   // Stabilisation wait is 2^(13 + select) ring clock cycles
   localparam int         SMWC_STAB_BASE_EXP = 13;
   localparam int         SMWC_CNT_W         = 21;
   localparam logic [2:0] SMWC_RDIV_MAX      = 3'h7;
   localparam int         SMWC_PRIO_W        = 3;
   localparam int         SMWC_VEC_W         = 3;
   localparam logic [2:0] SMWC_VEC_NMI_PIN   = 3'h0;
   localparam logic [2:0] SMWC_VEC_NMI_WDT   = 3'h1;
   localparam logic [2:0] SMWC_VEC_MASKABLE  = 3'h2;
   localparam int         SMWC_PORT_W        = 16;
   typedef enum logic [1:0]
   {
      SMWC_RUN,
      SMWC_STOP,
      SMWC_SETUP
   } smwc_state_e;
endpackage

// ---- hw/smwc_stop_wake.sv ----
// Purpose: Deep stop entry, wake, setup wait and clock gating
// Assumes: Ring clock enable pulse is synchronous to clk_i
// Notes:   Register data reads back one cycle after the read strobe
//
// Local design decisions: the plain strobed port and the address map.
`default_nettype none

// Functional notes
// - Any unmasked pin or watchdog NMI or maskable request wakes.
// - In a service routine a lower priority request only wakes.
// - In a service routine an NMI, or a higher priority request with interrupts enabled, is acknowledged.
// - An NMI wake waits the setup time then vectors to its handler.
// - A maskable wake waits setup, then vectors if enabled else resumes.
// - External reset in stop behaves exactly like a normal reset.
// - Interrupt controller only detects wakes; listed units halt.
// - Interval timer runs on ring/8, watchdog on undivided ring clock.
// - Serial channels run in stop only on their external clock.
// - Port pins hold their pre-stop state during stop.
// - CPU state and RAM are kept through stop and interrupt release.
// - Stop is entered by mode field 01 then setting the trigger bit.
// - Main oscillator stops and CPU and peripheral clocks cease.
// - Normal operation returns only after the selected wait elapses.
// - A source whose wake mask bit is 1 is ignored.
module smwc_stop_wake
(
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   input  wire logic [3:0]             reg_addr_i,
   input  wire logic [7:0]             reg_wdata_i,
   input  wire logic                   reg_write_i,
   input  wire logic                   reg_read_i,
   output logic      [7:0]             reg_rdata_o,
   input  wire logic                   ring_tick_i,
   input  wire logic                   nmi_pin_req_i,
   input  wire logic                   nmi_wdt_req_i,
   input  wire logic                   mask_req_i,
   input  wire logic [2:0]             mask_req_prio_i,
   input  wire logic                   in_service_i,
   input  wire logic [2:0]             service_prio_i,
   input  wire logic                   interrupts_enabled_state_i,
   input  wire logic [15:0]            port_out_i,
   output logic      [15:0]            port_out_o,
   output logic                        main_osc_en_o,
   output logic                        ring_osc_en_o,
   output logic                        cpu_clk_en_o,
   output logic                        periph_clk_en_o,
   output logic                        intc_detect_only_o,
   output logic                        interval_timer_en_o,
   output logic                        watchdog_unit_en_o,
   output logic                        sync_serial_channel_en_o,
   output logic                        async_serial_channel_en_o,
   output logic                        resume_o,
   output logic                        vector_o,
   output logic      [2:0]             vector_id_o,
   output logic                        ack_o,
   output logic                        stopped_o
);

   smwc_pkg::smwc_state_e state_reg;
   logic [7:0]                    power_save_control_reg;
   logic [7:0]                    standby_mode_select_reg;
   logic [2:0]                    stabilization_time_select;
   logic [7:0]                    clksel_reg;
   logic [smwc_pkg::SMWC_CNT_W-1:0] stab_cnt_reg;
   logic [smwc_pkg::SMWC_CNT_W-1:0] stab_limit;
   logic [2:0]                    rdiv_reg;
   logic                          rdiv8_tick;
   logic                          pnmi_wake;
   logic                          wnmi_wake;
   logic                          mint_wake;
   logic                          any_wake;
   logic                          higher_prio;
   logic                          take_ack;
   logic                          wake_ack_reg;
   logic [2:0]                    wake_vec_reg;
   logic                          wake_nmi_reg;
   logic                          enter_stop;
   logic                          stop_done;
   logic                          in_stop;

   // ----------------------------------------------------------------
   // Wake decode
   // ----------------------------------------------------------------
   // Masked sources ignored
   assign pnmi_wake = nmi_pin_req_i &
      ~power_save_control_reg[smwc_pkg::SMWC_BIT_MASK_PNMI];
   assign wnmi_wake = nmi_wdt_req_i &
      ~power_save_control_reg[smwc_pkg::SMWC_BIT_MASK_WDNM];
   assign mint_wake = mask_req_i &
      ~power_save_control_reg[smwc_pkg::SMWC_BIT_MASK_INT];
   assign any_wake = pnmi_wake | wnmi_wake | mint_wake;
   assign higher_prio = ~in_service_i | (mask_req_prio_i < service_prio_i);
   assign take_ack = pnmi_wake | wnmi_wake |
      (mint_wake & interrupts_enabled_state_i & higher_prio);
   assign enter_stop = reg_write_i &
      (reg_addr_i == smwc_pkg::SMWC_OFF_PSAVE) &
      reg_wdata_i[smwc_pkg::SMWC_BIT_TRIGGER] &
      (standby_mode_select_reg[1:0] == smwc_pkg::SMWC_MODE_STOP) &
      (state_reg == smwc_pkg::SMWC_RUN);
   assign stab_limit = smwc_pkg::SMWC_CNT_W'(1) <<
      (smwc_pkg::SMWC_STAB_BASE_EXP + int'(stabilization_time_select));
   assign stop_done = (state_reg == smwc_pkg::SMWC_SETUP) & ring_tick_i &
      (stab_cnt_reg == stab_limit - smwc_pkg::SMWC_CNT_W'(1));
   assign in_stop = (state_reg != smwc_pkg::SMWC_RUN);
   assign rdiv8_tick = ring_tick_i & (rdiv_reg == smwc_pkg::SMWC_RDIV_MAX);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Reset restarts sequence
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= smwc_pkg::SMWC_RUN;
      end
      else
      begin
         case (state_reg)
            smwc_pkg::SMWC_RUN:
            begin
               if (enter_stop)
               begin
                  state_reg <= smwc_pkg::SMWC_STOP;
               end
            end
            smwc_pkg::SMWC_STOP:
            begin
               if (any_wake)
               begin
                  state_reg <= smwc_pkg::SMWC_SETUP;
               end
            end
            smwc_pkg::SMWC_SETUP:
            begin
               if (stop_done)
               begin
                  state_reg <= smwc_pkg::SMWC_RUN;
               end
            end
            default:
            begin
               state_reg <= smwc_pkg::SMWC_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         stab_cnt_reg <= '0;
      end
      else if (state_reg != smwc_pkg::SMWC_SETUP)
      begin
         stab_cnt_reg <= '0;
      end
      else if (ring_tick_i)
      begin
         stab_cnt_reg <= stab_cnt_reg + smwc_pkg::SMWC_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdiv_reg <= '0;
      end
      else if (ring_tick_i)
      begin
         rdiv_reg <= rdiv_reg + 3'h1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wake_ack_reg <= 1'b0;
         wake_nmi_reg <= 1'b0;
         wake_vec_reg <= smwc_pkg::SMWC_VEC_NMI_PIN;
      end
      else if ((state_reg == smwc_pkg::SMWC_STOP) && any_wake)
      begin
         wake_ack_reg <= take_ack;
         wake_nmi_reg <= pnmi_wake | wnmi_wake;
         wake_vec_reg <= pnmi_wake ? smwc_pkg::SMWC_VEC_NMI_PIN :
                         wnmi_wake ? smwc_pkg::SMWC_VEC_NMI_WDT :
                                     smwc_pkg::SMWC_VEC_MASKABLE;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         resume_o    <= 1'b0;
         vector_o    <= 1'b0;
         ack_o       <= 1'b0;
         vector_id_o <= smwc_pkg::SMWC_VEC_NMI_PIN;
      end
      else
      begin
         resume_o    <= stop_done;
         vector_o    <= stop_done & wake_ack_reg;
         ack_o       <= stop_done & wake_ack_reg;
         vector_id_o <= wake_vec_reg;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         port_out_o <= '0;
      end
      else if (!in_stop)
      begin
         port_out_o <= port_out_i;
      end
   end

   // ----------------------------------------------------------------
   // Clock gating
   // ----------------------------------------------------------------
   // Main clocks cease
   assign main_osc_en_o   = ~in_stop;
   assign cpu_clk_en_o    = ~in_stop;
   assign periph_clk_en_o = ~in_stop;
   assign stopped_o       = in_stop;
   assign intc_detect_only_o = in_stop;
   assign ring_osc_en_o = 1'b1;
   assign interval_timer_en_o = ~in_stop ? 1'b1 :
      clksel_reg[smwc_pkg::SMWC_BIT_TMR_RDIV8] & rdiv8_tick;
   assign watchdog_unit_en_o = ~in_stop ? 1'b1 :
      clksel_reg[smwc_pkg::SMWC_BIT_WDT_RING] & ring_tick_i;
   assign sync_serial_channel_en_o = ~in_stop |
      clksel_reg[smwc_pkg::SMWC_BIT_SYNC_EXT];
   assign async_serial_channel_en_o = ~in_stop |
      clksel_reg[smwc_pkg::SMWC_BIT_ASYN_EXT];

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         power_save_control_reg    <= smwc_pkg::SMWC_PSAVE_RST;
         standby_mode_select_reg   <= smwc_pkg::SMWC_MODE_RST;
         stabilization_time_select <= smwc_pkg::SMWC_STAB_RST;
         clksel_reg                <= smwc_pkg::SMWC_CLKSEL_RST;
      end
      else
      begin
         if (stop_done)
         begin
            power_save_control_reg[smwc_pkg::SMWC_BIT_TRIGGER] <= 1'b0;
         end
         else if (reg_write_i && !in_stop)
         begin
            case (reg_addr_i)
               smwc_pkg::SMWC_OFF_PSAVE:
                  power_save_control_reg <=
                     reg_wdata_i & smwc_pkg::SMWC_PSAVE_WMSK;
               smwc_pkg::SMWC_OFF_MODE:
                  standby_mode_select_reg <=
                     reg_wdata_i & smwc_pkg::SMWC_MODE_WMSK;
               smwc_pkg::SMWC_OFF_STAB:
                  stabilization_time_select <=
                     reg_wdata_i[2:0] & smwc_pkg::SMWC_STAB_WMSK;
               smwc_pkg::SMWC_OFF_CLKSEL:
                  clksel_reg <= reg_wdata_i & smwc_pkg::SMWC_CLKSEL_WMSK;
               default:
                  clksel_reg <= clksel_reg;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         reg_rdata_o <= '0;
      end
      else if (reg_read_i)
      begin
         case (reg_addr_i)
            smwc_pkg::SMWC_OFF_PSAVE:  reg_rdata_o <= power_save_control_reg;
            smwc_pkg::SMWC_OFF_MODE:   reg_rdata_o <= standby_mode_select_reg;
            smwc_pkg::SMWC_OFF_STAB:
               reg_rdata_o <= {5'h00, stabilization_time_select};
            smwc_pkg::SMWC_OFF_CLKSEL: reg_rdata_o <= clksel_reg;
            smwc_pkg::SMWC_OFF_STATUS:
               reg_rdata_o <= {6'h00, state_reg};
            default:                   reg_rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         reg_rdata_o <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_wake_seen;
      (state_reg == smwc_pkg::SMWC_STOP) && any_wake;
   endsequence

   AST_WAKE_TO_SETUP: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      s_wake_seen |=> (state_reg == smwc_pkg::SMWC_SETUP))
      else $error("wake request did not leave stop");

   AST_MASKED_STAYS: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      (state_reg == smwc_pkg::SMWC_STOP) && !any_wake
      |=> (state_reg == smwc_pkg::SMWC_STOP))
      else $error("left stop without an unmasked source");

   AST_ENTRY: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      $rose(state_reg == smwc_pkg::SMWC_STOP) |-> $past(enter_stop))
      else $error("stop entered without the entry sequence");

   AST_CLOCKS_OFF: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      in_stop |-> !cpu_clk_en_o && !main_osc_en_o && ring_osc_en_o)
      else $error("main clocks running in stop");

   AST_PORT_HOLD: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      in_stop && $past(in_stop) |-> $stable(port_out_o))
      else $error("port pins changed during stop");

   AST_NO_EARLY_RESUME: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      $fell(in_stop) |-> $past(stop_done))
      else $error("resumed before setup wait elapsed");

   AST_LOW_NO_ACK: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      s_wake_seen and (!pnmi_wake && !wnmi_wake && in_service_i
      && !(mask_req_prio_i < service_prio_i)) |=> !wake_ack_reg)
      else $error("lower priority request acknowledged");

   AST_NMI_VECTOR: assert property (@(posedge clk_i)
      disable iff (!reset_n_i)
      stop_done && wake_nmi_reg |=> vector_o && ack_o && resume_o)
      else $error("nmi wake did not vector");

endmodule

`default_nettype wire

// ---- verification/smwc_partner_model.sv ----
// Purpose: Far-side model of wake sources, controller and core
// Assumes: Requests are levels held until acknowledged or cleared
// Notes:   Port values keep moving so a frozen port shows
`default_nettype none
module smwc_partner_model
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic [1:0]  raise_i,
   input  wire logic        clear_i,
   input  wire logic        ack_i,
   input  wire logic        ring_osc_en_i,
   output logic             nmi_pin_req_o,
   output logic             nmi_wdt_req_o,
   output logic             mask_req_o,
   output logic             ring_tick_o,
   output logic [15:0]      port_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Ring clock and core port activity
   // ----------------------------------------------------------------
   // Ring ticks continuously
   assign ring_tick_o = ring_osc_en_i;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         port_o <= 16'h0000;
      else
         port_o <= port_o + 16'h0001;
   end
   // ----------------------------------------------------------------
   // Request lines
   // ----------------------------------------------------------------
   // Held while pending
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         nmi_pin_req_o <= 1'b0;
         nmi_wdt_req_o <= 1'b0;
         mask_req_o    <= 1'b0;
      end
      else if (clear_i || ack_i)
      begin
         nmi_pin_req_o <= 1'b0;
         nmi_wdt_req_o <= 1'b0;
         mask_req_o    <= 1'b0;
      end
      else
      begin
         if (raise_i == 2'h1)
            nmi_pin_req_o <= 1'b1;
         if (raise_i == 2'h2)
            nmi_wdt_req_o <= 1'b1;
         if (raise_i == 2'h3)
            mask_req_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the deep stop wake controller
// Assumes: Ring tick every cycle, stabilisation select 0
// Notes:   Each wake waits 8192 ring ticks
`default_nettype none
`define CHK(g, e) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i, reset_n_i, reg_write_i, reg_read_i, mask_req_i;
   logic nmi_pin_req_i, nmi_wdt_req_i, ring_tick_i, in_service_i;
   logic interrupts_enabled_state_i, clear, main_osc_en_o, ring_osc_en_o;
   logic cpu_clk_en_o, periph_clk_en_o, intc_detect_only_o, resume_o;
   logic interval_timer_en_o, watchdog_unit_en_o, vector_o, ack_o;
   logic sync_serial_channel_en_o, async_serial_channel_en_o, stopped_o;
   logic [3:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i, reg_rdata_o, d;
   logic [2:0]  mask_req_prio_i, service_prio_i, vector_id_o;
   logic [15:0] port_out_i, port_out_o;
   logic [1:0]  raise;
   int          errors, compares, ti, tw;
   smwc_stop_wake i_smwc_stop_wake
   (
      .clk_i                      (clk_i),
      .reset_n_i                  (reset_n_i),
      .reg_addr_i                 (reg_addr_i),
      .reg_wdata_i                (reg_wdata_i),
      .reg_write_i                (reg_write_i),
      .reg_read_i                 (reg_read_i),
      .reg_rdata_o                (reg_rdata_o),
      .ring_tick_i                (ring_tick_i),
      .nmi_pin_req_i              (nmi_pin_req_i),
      .nmi_wdt_req_i              (nmi_wdt_req_i),
      .mask_req_i                 (mask_req_i),
      .mask_req_prio_i            (mask_req_prio_i),
      .in_service_i               (in_service_i),
      .service_prio_i             (service_prio_i),
      .interrupts_enabled_state_i (interrupts_enabled_state_i),
      .port_out_i                 (port_out_i),
      .port_out_o                 (port_out_o),
      .main_osc_en_o              (main_osc_en_o),
      .ring_osc_en_o              (ring_osc_en_o),
      .cpu_clk_en_o               (cpu_clk_en_o),
      .periph_clk_en_o            (periph_clk_en_o),
      .intc_detect_only_o         (intc_detect_only_o),
      .interval_timer_en_o        (interval_timer_en_o),
      .watchdog_unit_en_o         (watchdog_unit_en_o),
      .sync_serial_channel_en_o   (sync_serial_channel_en_o),
      .async_serial_channel_en_o  (async_serial_channel_en_o),
      .resume_o                   (resume_o),
      .vector_o                   (vector_o),
      .vector_id_o                (vector_id_o),
      .ack_o                      (ack_o),
      .stopped_o                  (stopped_o)
   );
   smwc_partner_model i_smwc_partner_model
   (
      .clk_i         (clk_i),
      .reset_n_i     (reset_n_i),
      .raise_i       (raise),
      .clear_i       (clear),
      .ack_i         (ack_o),
      .ring_osc_en_i (ring_osc_en_o),
      .nmi_pin_req_o (nmi_pin_req_i),
      .nmi_wdt_req_o (nmi_wdt_req_i),
      .mask_req_o    (mask_req_i),
      .ring_tick_o   (ring_tick_i),
      .port_o        (port_out_i)
   );
   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clk_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_i);
      reg_read_i <= 1'b0;
      #1;
      v = reg_rdata_o;
   endtask
   task automatic enter_stop(input logic [7:0] m);
      wr(smwc_pkg::SMWC_OFF_MODE, 8'h01);
      wr(smwc_pkg::SMWC_OFF_PSAVE, m | 8'h02);
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // ----------------------------------------------------------------
   // One stop and wake with expected outcome
   // ----------------------------------------------------------------
   task automatic wake(input logic [1:0] k, input logic isv,
                       input logic [2:0] sp, input logic [2:0] mp,
                       input logic ie, input logic ea, input logic ev,
                       input logic [2:0] ei);
      int          n;
      logic [15:0] held;
      logic        moved;
      in_service_i               <= isv;
      service_prio_i             <= sp;
      mask_req_prio_i            <= mp;
      interrupts_enabled_state_i <= ie;
      enter_stop(8'h00);
      `CHK(stopped_o, 1'b1)
      `CHK({main_osc_en_o, cpu_clk_en_o, periph_clk_en_o}, 3'h0)
      `CHK(intc_detect_only_o, 1'b1)
      `CHK({interval_timer_en_o, watchdog_unit_en_o}, 2'h0)
      `CHK(sync_serial_channel_en_o, 1'b0)
      `CHK(async_serial_channel_en_o, 1'b0)
      held = port_out_o;
      moved = 1'b0;
      n = 0;
      @(posedge clk_i);
      raise <= k;
      @(posedge clk_i);
      raise <= 2'h0;
      while (n < 9000)
      begin
         @(posedge clk_i);
         #1;
         if (stopped_o === 1'b1 && port_out_o !== held)
            moved = 1'b1;
         if (resume_o === 1'b1)
            break;
         n++;
      end
      `CHK(n >= 8192 && n <= 8200, 1'b1)
      `CHK(moved, 1'b0)
      `CHK(ack_o, ea)
      `CHK(vector_o, ev)
      if (ev)
         `CHK(vector_id_o, ei)
      `CHK(stopped_o, 1'b0)
      @(posedge clk_i);
      clear <= 1'b1;
      @(posedge clk_i);
      clear <= 1'b0;
      $display("wake test kind %0d done", k);
   endtask
   task automatic stop_test;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial
   begin
      #300000;
      errors++;
      stop_test();
   end
   initial
   begin
      {reset_n_i, reg_write_i, reg_read_i, in_service_i, clear} = '0;
      {reg_addr_i, reg_wdata_i, mask_req_prio_i, service_prio_i} = '0;
      {interrupts_enabled_state_i, raise} = '0;
      errors = 0;
      compares = 0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rd(smwc_pkg::SMWC_OFF_STAB, d);
      `CHK(d, {5'h00, smwc_pkg::SMWC_STAB_RST})
      rd(smwc_pkg::SMWC_OFF_STATUS, d);
      `CHK(d, 8'h00)
      rd(4'h9, d);
      `CHK(d, 8'h00)
      `CHK(ring_osc_en_o, 1'b1)
      `CHK(port_out_o, port_out_i - 16'h0001)
      wr(smwc_pkg::SMWC_OFF_STAB, 8'h00);
      wr(smwc_pkg::SMWC_OFF_CLKSEL, 8'h0f);
      wr(smwc_pkg::SMWC_OFF_MODE, 8'h02);
      wr(smwc_pkg::SMWC_OFF_PSAVE, 8'h02);
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(stopped_o, 1'b0)
      wr(smwc_pkg::SMWC_OFF_PSAVE, 8'h00);
      $display("entry test done");
      enter_stop(8'hd0);
      ti = 0;
      tw = 0;
      repeat (16)
      begin
         @(posedge clk_i);
         #1;
         ti += int'(interval_timer_en_o === 1'b1);
         tw += int'(watchdog_unit_en_o === 1'b1);
      end
      `CHK(ti, 2)
      `CHK(tw, 16)
      `CHK(sync_serial_channel_en_o, 1'b1)
      `CHK(async_serial_channel_en_o, 1'b1)
      for (int k = 1; k < 4; k++)
      begin
         @(posedge clk_i);
         raise <= k[1:0];
      end
      @(posedge clk_i);
      raise <= 2'h0;
      repeat (40) @(posedge clk_i);
      #1;
      `CHK(stopped_o, 1'b1)
      rd(smwc_pkg::SMWC_OFF_STATUS, d);
      `CHK(d, 8'h01)
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1;
      `CHK(stopped_o, 1'b0)
      rd(smwc_pkg::SMWC_OFF_STAB, d);
      `CHK(d, {5'h00, smwc_pkg::SMWC_STAB_RST})
      rd(smwc_pkg::SMWC_OFF_CLKSEL, d);
      `CHK(d, smwc_pkg::SMWC_CLKSEL_RST)
      $display("mask and reset test done");
      wr(smwc_pkg::SMWC_OFF_STAB, 8'h00);
      wake(2'h1, 1'b0, 3'h0, 3'h0, 1'b1, 1'b1, 1'b1, 3'h0);
      wake(2'h2, 1'b1, 3'h0, 3'h0, 1'b1, 1'b1, 1'b1, 3'h1);
      wake(2'h3, 1'b1, 3'h2, 3'h5, 1'b1, 1'b0, 1'b0, 3'h2);
      wake(2'h3, 1'b1, 3'h3, 3'h1, 1'b1, 1'b1, 1'b1, 3'h2);
      wake(2'h3, 1'b0, 3'h0, 3'h4, 1'b0, 1'b0, 1'b0, 3'h2);
      rd(smwc_pkg::SMWC_OFF_STAB, d);
      `CHK(d, 8'h00)
      stop_test();
   end
endmodule
`default_nettype wire
